/* inc/e1t_pkg.sv */
// Purpose: Shared constants for the eight-channel E1 transmit alarm and loopback control
// Assumes: 50 MHz master clock, 8-bit register port with 6-bit address
// Notes: Timing counts are in master clock cycles, except DMO_CYC, which counts transmit clock rises
package e1t_pkg;
   localparam int NCH = 8;
   localparam int AW = 6;
   localparam int DW = 8;
   localparam int MCLK_PERIOD_NS = 20;
   // Register map
   localparam logic [5:0] ADDR_GLOBAL = 6'h00;
   localparam logic [5:0] CTRL_BASE = 6'h10;
   localparam logic [5:0] STAT_BASE = 6'h18;
   // Global register fields
   localparam int GB_HWMODE = 0;
   localparam logic [7:0] GLOBAL_RST = 8'h00;
   // Channel control fields
   localparam int CB_FORCE = 0;
   localparam int CB_AUTO = 1;
   localparam int CB_LALB = 2;
   localparam int CB_RLB = 3;
   localparam int CB_DLB = 4;
   localparam int CB_IE = 5;
   localparam int CB_RXHIZ = 6;
   localparam int CB_TXOFF = 7;
   localparam logic [7:0] CTRL_RST = 8'h00;
   // Channel status fields
   localparam int SB_LOS = 0;
   localparam int SB_DMO = 1;
   localparam int SB_DMOCHG = 2;
   // Timing counts
   localparam logic [4:0] STUCK_CYC = 5'h10;
   localparam logic [7:0] DMO_CYC = 8'h80;
   localparam logic [4:0] AO_DIV = 5'h18;
endpackage

/* rtl/e1t_sync2.sv */
// Purpose: Two-flop synchroniser for a bundle of asynchronous levels
// Assumes: Each bit is an independent level
// Notes: First stage feeds only the second stage
`timescale 1ns/100ps
module e1t_sync2 #(
   parameter int W = 1
) (
   input wire logic clk_i, // Sampling clock
   input wire logic rst_n_i, // Active-low async reset
   input wire logic [W-1:0] d_i, // Asynchronous levels
   output logic [W-1:0] q_o // Synchronised levels
);
   logic [W-1:0] meta_r;
   logic [W-1:0] sync_r;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_r <= '0;
         sync_r <= '0;
      end else begin
         meta_r <= d_i;
         sync_r <= meta_r;
      end
   end

   assign q_o = sync_r;
endmodule

/* rtl/e1t_tx_ctrl.sv */
// Purpose: Per-channel all-ones, clock-stuck, driver monitor and loopback control for eight E1 channels
// Assumes: Line-side rails are digital pulse levels; all line and framer pin inputs are asynchronous to ref_clk_i, the register port is synchronous
// Notes: Transmit rails are taken on the falling edge of the transmit clock as seen by ref_clk_i
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
module e1t_tx_ctrl
   import e1t_pkg::*;
(
   input wire logic ref_clk_i, // Master clock, 50 MHz
   input wire logic reset_n_i, // Async reset, active low
   input wire logic [AW-1:0] addr_i, // Register address
   input wire logic [DW-1:0] wr_data_i, // Register write data
   input wire logic wr_i, // Write strobe
   input wire logic rd_i, // Read strobe
   output logic [DW-1:0] rd_data_o, // Read data, cycle after strobe
   input wire logic [NCH-1:0] tx_line_clock_i, // System transmit clock per channel
   input wire logic [NCH-1:0] tx_pos_rail_i, // System transmit positive rail
   input wire logic [NCH-1:0] tx_neg_rail_i, // System transmit negative rail
   input wire logic [NCH-1:0] rx_line_in_a_i, // Sliced receive line, positive pulses
   input wire logic [NCH-1:0] rx_line_in_b_i, // Sliced receive line, negative pulses
   input wire logic [NCH-1:0] rx_rec_clk_i, // Recovered receive clock
   input wire logic [NCH-1:0] rx_loss_of_signal_i, // Receive loss of signal from slicer
   output logic [NCH-1:0] tx_line_out_a_o, // Transmit line positive pulse
   output logic [NCH-1:0] tx_line_out_b_o, // Transmit line negative pulse
   output logic [NCH-1:0] tx_line_oe_n_o, // Transmit driver enable, low drives
   output logic [NCH-1:0] rx_pos_rail_o, // Receive positive rail to system
   output logic [NCH-1:0] rx_neg_rail_o, // Receive negative rail to system
   output logic [NCH-1:0] rx_clk_o, // Receive clock to system
   output logic [NCH-1:0] rx_hiz_o, // Receiver termination high impedance
   output logic [NCH-1:0] los_alarm_o, // Loss of signal alarm pin
   output logic [NCH-1:0] driver_fail_flag_o, // Driver fail alarm pin
   output logic int_n_o // Interrupt, active low
);
   logic rst_q1_r;
   logic rst_n;
   logic [7*NCH-1:0] sync_q;
   logic [NCH-1:0] tx_line_clock_s, txp_s, txn_s, rxa_s, rxb_s, rxc_s, los_s;

   // Channel state
   logic [NCH-1:0] tx_line_clock_p_r, tx_line_clock_p_nxt;
   logic [4:0] lvl_cnt_r [NCH];
   logic [4:0] lvl_cnt_nxt [NCH];
   logic [4:0] div_cnt_r [NCH];
   logic [4:0] div_cnt_nxt [NCH];
   logic [7:0] dmo_cnt_r [NCH];
   logic [7:0] dmo_cnt_nxt [NCH];
   logic [NCH-1:0] pol_r, pol_nxt;
   logic [NCH-1:0] tx_a_r, tx_a_nxt, tx_b_r, tx_b_nxt, oe_n_r, oe_n_nxt;
   logic [NCH-1:0] rx_pos_r, rx_pos_nxt, rx_neg_r, rx_neg_nxt, rx_clk_r, rx_clk_nxt;
   logic [NCH-1:0] dmo_r, dmo_nxt, los_r, los_nxt, hiz_r, hiz_nxt;
   logic [NCH-1:0] stuck_lo, stuck_hi, ao_act, tick, rise, pulse, dmo_chg;

   // Register state
   logic [7:0] glob_r, glob_nxt;
   logic [7:0] ctrl_r [NCH];
   logic [7:0] ctrl_nxt [NCH];
   logic [NCH-1:0] sticky_r, sticky_nxt;
   logic [DW-1:0] rd_data_r, rd_data_nxt;
   logic int_n_r, int_n_nxt;
   logic hw_mode;

   function automatic logic addr_hit(input logic [AW-1:0] a, input logic [AW-1:0] base, input int idx);
      addr_hit = (a == (base + AW'(idx)));
   endfunction

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_q1_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_q1_r <= 1'b1;
         rst_n <= rst_q1_r;
      end
   end

   e1t_sync2 #(.W(7*NCH)) u_sync (
      .clk_i(ref_clk_i),
      .rst_n_i(rst_n),
      .d_i({tx_line_clock_i, tx_pos_rail_i, tx_neg_rail_i, rx_line_in_a_i, rx_line_in_b_i,
            rx_rec_clk_i, rx_loss_of_signal_i}),
      .q_o(sync_q)
   );
   assign {tx_line_clock_s, txp_s, txn_s, rxa_s, rxb_s, rxc_s, los_s} = sync_q;
   assign hw_mode = glob_r[GB_HWMODE];

   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         tx_line_clock_p_nxt[c] = tx_line_clock_s[c];
         // Count consecutive master cycles at one transmit clock level
         if (tx_line_clock_s[c] != tx_line_clock_p_r[c]) begin
            lvl_cnt_nxt[c] = 5'h01;
         end else if (lvl_cnt_r[c] == STUCK_CYC) begin
            lvl_cnt_nxt[c] = lvl_cnt_r[c];
         end else begin
            lvl_cnt_nxt[c] = lvl_cnt_r[c] + 5'h01;
         end
         stuck_lo[c] = hw_mode && (lvl_cnt_r[c] == STUCK_CYC) && !tx_line_clock_s[c];
         stuck_hi[c] = hw_mode && (lvl_cnt_r[c] == STUCK_CYC) && tx_line_clock_s[c];
         // Master-timed bit rate while the transmit clock is held high
         if (stuck_hi[c] && (div_cnt_r[c] != AO_DIV - 5'h01)) begin
            div_cnt_nxt[c] = div_cnt_r[c] + 5'h01;
         end else begin
            div_cnt_nxt[c] = 5'h00;
         end
         tick[c] = stuck_hi[c] ? (div_cnt_r[c] == AO_DIV - 5'h01) : (tx_line_clock_p_r[c] && !tx_line_clock_s[c]);
         rise[c] = !tx_line_clock_p_r[c] && tx_line_clock_s[c];
         ao_act[c] = ctrl_r[c][CB_FORCE] || (ctrl_r[c][CB_AUTO] && los_s[c]) || stuck_hi[c];

         oe_n_nxt[c] = ctrl_r[c][CB_TXOFF] || stuck_lo[c];
         tx_a_nxt[c] = tx_a_r[c];
         tx_b_nxt[c] = tx_b_r[c];
         pol_nxt[c] = pol_r[c];
         if (ctrl_r[c][CB_RLB]) begin
            // Remote loop owns the line; system clock and rails unused
            tx_a_nxt[c] = rxa_s[c];
            tx_b_nxt[c] = rxb_s[c];
         end else if (tick[c]) begin
            if (ao_act[c]) begin
               // Alternate mark polarity so the all-ones line stays DC free
               tx_a_nxt[c] = !pol_r[c];
               tx_b_nxt[c] = pol_r[c];
               pol_nxt[c] = !pol_r[c];
            end else begin
               tx_a_nxt[c] = txp_s[c];
               tx_b_nxt[c] = txn_s[c];
            end
         end
         pulse[c] = !oe_n_nxt[c] && (tx_a_nxt[c] || tx_b_nxt[c]) && !(tx_a_r[c] || tx_b_r[c]);

         // Driver monitor counts transmit clocks since the last emitted mark
         dmo_nxt[c] = dmo_r[c];
         dmo_cnt_nxt[c] = dmo_cnt_r[c];
         if (pulse[c]) begin
            dmo_cnt_nxt[c] = 8'h00;
            dmo_nxt[c] = 1'b0;
         end else if (rise[c]) begin
            if (dmo_cnt_r[c] == DMO_CYC) begin
               dmo_nxt[c] = 1'b1;
            end else begin
               dmo_cnt_nxt[c] = dmo_cnt_r[c] + 8'h01;
            end
         end
         dmo_chg[c] = dmo_nxt[c] != dmo_r[c];
         los_nxt[c] = los_s[c];
         hiz_nxt[c] = ctrl_r[c][CB_RXHIZ];

         // Receive path runs regardless of termination setting
         if (ctrl_r[c][CB_DLB]) begin
            rx_pos_nxt[c] = txp_s[c];
            rx_neg_nxt[c] = txn_s[c];
            rx_clk_nxt[c] = tx_line_clock_s[c];
         end else if (ctrl_r[c][CB_LALB]) begin
            rx_pos_nxt[c] = tx_a_r[c];
            rx_neg_nxt[c] = tx_b_r[c];
            rx_clk_nxt[c] = tx_line_clock_s[c];
         end else begin
            rx_pos_nxt[c] = rxa_s[c];
            rx_neg_nxt[c] = rxb_s[c];
            rx_clk_nxt[c] = rxc_s[c];
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         tx_line_clock_p_r <= '0;
         pol_r <= '0;
         tx_a_r <= '0;
         tx_b_r <= '0;
         oe_n_r <= '1;
         rx_pos_r <= '0;
         rx_neg_r <= '0;
         rx_clk_r <= '0;
         dmo_r <= '0;
         los_r <= '0;
         hiz_r <= '0;
         for (int c = 0; c < NCH; c++) begin
            lvl_cnt_r[c] <= 5'h00;
            div_cnt_r[c] <= 5'h00;
            dmo_cnt_r[c] <= 8'h00;
         end
      end else begin
         tx_line_clock_p_r <= tx_line_clock_p_nxt;
         pol_r <= pol_nxt;
         tx_a_r <= tx_a_nxt;
         tx_b_r <= tx_b_nxt;
         oe_n_r <= oe_n_nxt;
         rx_pos_r <= rx_pos_nxt;
         rx_neg_r <= rx_neg_nxt;
         rx_clk_r <= rx_clk_nxt;
         dmo_r <= dmo_nxt;
         los_r <= los_nxt;
         hiz_r <= hiz_nxt;
         lvl_cnt_r <= lvl_cnt_nxt;
         div_cnt_r <= div_cnt_nxt;
         dmo_cnt_r <= dmo_cnt_nxt;
      end
   end

   always_comb begin
      glob_nxt = glob_r;
      rd_data_nxt = '0;
      if (wr_i && (addr_i == ADDR_GLOBAL)) begin
         glob_nxt = wr_data_i;
      end
      if (rd_i && (addr_i == ADDR_GLOBAL)) begin
         rd_data_nxt = glob_r;
      end
      for (int c = 0; c < NCH; c++) begin
         ctrl_nxt[c] = ctrl_r[c];
         if (wr_i && addr_hit(addr_i, CTRL_BASE, c)) begin
            ctrl_nxt[c] = wr_data_i;
         end
         if (rd_i && addr_hit(addr_i, CTRL_BASE, c)) begin
            rd_data_nxt = ctrl_r[c];
         end
         sticky_nxt[c] = sticky_r[c];
         if (rd_i && addr_hit(addr_i, STAT_BASE, c)) begin
            rd_data_nxt = '0;
            rd_data_nxt[SB_LOS] = los_r[c];
            rd_data_nxt[SB_DMO] = dmo_r[c];
            rd_data_nxt[SB_DMOCHG] = sticky_r[c];
            sticky_nxt[c] = 1'b0;
         end
         // A change in the same cycle as the read is kept
         if (dmo_chg[c]) begin
            sticky_nxt[c] = 1'b1;
         end
      end
      int_n_nxt = 1'b1;
      for (int c = 0; c < NCH; c++) begin
         if (sticky_r[c] && ctrl_r[c][CB_IE]) begin
            int_n_nxt = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         glob_r <= GLOBAL_RST;
         sticky_r <= '0;
         rd_data_r <= '0;
         int_n_r <= 1'b1;
         for (int c = 0; c < NCH; c++) begin
            ctrl_r[c] <= CTRL_RST;
         end
      end else begin
         glob_r <= glob_nxt;
         sticky_r <= sticky_nxt;
         rd_data_r <= rd_data_nxt;
         int_n_r <= int_n_nxt;
         ctrl_r <= ctrl_nxt;
      end
   end

   assign tx_line_out_a_o = tx_a_r;
   assign tx_line_out_b_o = tx_b_r;
   assign tx_line_oe_n_o = oe_n_r;
   assign rx_pos_rail_o = rx_pos_r;
   assign rx_neg_rail_o = rx_neg_r;
   assign rx_clk_o = rx_clk_r;
   assign rx_hiz_o = hiz_r;
   assign los_alarm_o = los_r;
   assign driver_fail_flag_o = dmo_r;
   assign int_n_o = int_n_r;
   assign rd_data_o = rd_data_r;

   localparam int AO_WIN = 30;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n);

   for (genvar g = 0; g < NCH; g++) begin : g_chk
      sequence s_held_high;
         stuck_hi[g] [*8];
      endsequence
      sequence s_int_path;
         dmo_chg[g] && ctrl_r[g][CB_IE] ##1 sticky_r[g];
      endsequence

      chk_auto_ones_mark: assert property (
         (ao_act[g] && !ctrl_r[g][CB_RLB] && tick[g]) |=> (tx_a_r[g] ^ tx_b_r[g]))
         else $error("all-ones tick without a mark");
      chk_normal_data: assert property (
         (!ao_act[g] && !ctrl_r[g][CB_RLB] && tick[g]) |=> (tx_a_r[g] == $past(txp_s[g])))
         else $error("rail data not sent after all-ones ends");
      chk_stuck_low_hiz: assert property (
         (hw_mode && lvl_cnt_r[g] == STUCK_CYC && !tx_line_clock_s[g]) |=> oe_n_r[g])
         else $error("driver not tristated on stuck-low clock");
      chk_stuck_high_ones: assert property (
         (s_held_high ##0 (!ctrl_r[g][CB_RLB] && !oe_n_r[g]))
         |-> ##[0:AO_WIN] ((tx_a_r[g] || tx_b_r[g]) || !stuck_hi[g]))
         else $error("no master-timed mark on stuck-high clock");
      chk_dmo_sets: assert property (
         (rise[g] && dmo_cnt_r[g] == DMO_CYC && !pulse[g]) |=> dmo_r[g])
         else $error("driver fail flag not set after 128 clocks");
      chk_dmo_clears: assert property (
         pulse[g] |=> (!dmo_r[g] && dmo_cnt_r[g] == 8'h00))
         else $error("driver fail flag not cleared by pulse");
      chk_int_asserts: assert property (
         s_int_path |-> ##1 !int_n_o)
         else $error("interrupt not driven low on flag change");
      chk_read_clears: assert property (
         (rd_i && addr_hit(addr_i, STAT_BASE, g) && !dmo_chg[g]) |=> !sticky_r[g])
         else $error("status not cleared on read");
      chk_remote_prio: assert property (
         ctrl_r[g][CB_RLB] |=> (tx_a_r[g] == $past(rxa_s[g]) && tx_b_r[g] == $past(rxb_s[g])))
         else $error("remote loop not on transmit line");
      chk_digital_loop: assert property (
         ctrl_r[g][CB_DLB] |=> (rx_pos_r[g] == $past(txp_s[g]) && rx_clk_r[g] == $past(tx_line_clock_s[g])))
         else $error("digital loop not on receive outputs");
      chk_analog_loop: assert property (
         (ctrl_r[g][CB_LALB] && !ctrl_r[g][CB_DLB]) |=> (rx_pos_r[g] == $past(tx_a_r[g])))
         else $error("local analog loop not on receive outputs");
   end
endmodule

/* tb/e1t_framer_model.sv */
// Purpose: Behavioural framer driving the transmit clock and rails
// Assumes: Rails launch on the rising clock edge and are taken on the falling one
// Notes: While stopped the clock stands at idle_lvl_i and rails toggle, so stale data never looks valid
`timescale 1ns/100ps
module e1t_framer_model
   import e1t_pkg::*;
(
   input wire logic run_i, // Clock and data running
   input wire logic idle_lvl_i, // Clock level while stopped
   output logic [NCH-1:0] tx_line_clock_o, // Transmit clock, all channels
   output logic [NCH-1:0] tx_pos_rail_o, // Positive rail
   output logic [NCH-1:0] tx_neg_rail_o // Negative rail
);
   logic ck;
   logic [NCH-1:0] r1;
   initial begin
      ck = 1'b0;
      tx_pos_rail_o = '0;
      tx_neg_rail_o = '0;
      #7;
      forever #80 ck = ~ck;
   end
   assign tx_line_clock_o = run_i ? {NCH{ck}} : {NCH{idle_lvl_i}};
   // Half a bit of hold after the taking edge
   always @(posedge ck) begin
      r1 = NCH'($urandom);
      if (run_i) begin
         tx_pos_rail_o <= r1;
         tx_neg_rail_o <= NCH'($urandom) & ~r1; // Never both marks at once
      end else begin
         tx_pos_rail_o <= ~tx_pos_rail_o;
         tx_neg_rail_o <= ~tx_neg_rail_o;
      end
   end
endmodule

/* tb/tb_top.sv */
// Purpose: Self-checking bench for the E1 transmit alarm and loopback control
// Assumes: Framer model on the system side, bench drives the line side and registers
// Notes: Register reads are checked from a queue by a separate watcher
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top;
   import e1t_pkg::*;
   logic ref_clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0, run = 1'b0, idle = 1'b0, rd_seen = 1'b0;
   logic [AW-1:0] addr = '0;
   logic [DW-1:0] wdat = '0, rdat, e_r;
   logic [NCH-1:0] tx_line_clock, tx_pos_rail, tx_neg_rail, rxa = '0, rxb = '0, rclk = '0, los = '0, r1, r2;
   logic [NCH-1:0] txa, txb, oen, rxp, rxn, rxc, hiz, losa, dff, pa, pn, prev_a, wr6, m, ao, alt;
   logic [DW-1:0] wv[NCH];
   // Channel 7 starts as the idle backup: driver off, receiver high impedance
   logic [DW-1:0] role[NCH] = '{8'h01, 8'h02, 8'h09, 8'h10, 8'h04, 8'h20, 8'h00, 8'hC0};
   logic [1:0] last;
   logic mk5_d = 1'b0, ck5_d = 1'b0;
   logic int_n, lph;
   logic [DW-1:0] exp_q[$];
   int errors = 0, cmp_count = 0, k, n, quiet = 0;

   initial begin
      forever #10 ref_clk = ~ref_clk;
   end
   always begin
      repeat (4) @(posedge ref_clk);
      rclk <= ~rclk;
   end

   e1t_tx_ctrl u_e1t_tx_ctrl (.ref_clk_i(ref_clk), .reset_n_i(reset_n), .addr_i(addr), .wr_data_i(wdat),
      .wr_i(wr), .rd_i(rd), .rd_data_o(rdat), .tx_line_clock_i(tx_line_clock), .tx_pos_rail_i(tx_pos_rail),
      .tx_neg_rail_i(tx_neg_rail), .rx_line_in_a_i(rxa), .rx_line_in_b_i(rxb), .rx_rec_clk_i(rclk),
      .rx_loss_of_signal_i(los), .tx_line_out_a_o(txa), .tx_line_out_b_o(txb), .tx_line_oe_n_o(oen),
      .rx_pos_rail_o(rxp), .rx_neg_rail_o(rxn), .rx_clk_o(rxc), .rx_hiz_o(hiz), .los_alarm_o(losa),
      .driver_fail_flag_o(dff), .int_n_o(int_n));
   e1t_framer_model u_e1t_framer_model (.run_i(run), .idle_lvl_i(idle), .tx_line_clock_o(tx_line_clock),
      .tx_pos_rail_o(tx_pos_rail), .tx_neg_rail_o(tx_neg_rail));

   task automatic wr_reg(input logic [AW-1:0] a, input logic [DW-1:0] d);
      @(posedge ref_clk);
      wr <= 1'b1;
      addr <= a;
      wdat <= d;
      @(posedge ref_clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [AW-1:0] a, input logic [DW-1:0] e);
      @(posedge ref_clk);
      rd <= 1'b1;
      addr <= a;
      exp_q.push_back(e);
      @(posedge ref_clk);
      rd <= 1'b0;
   endtask
   task automatic tick(input int c);
      repeat (c) @(posedge ref_clk);
      #1;
   endtask
   task automatic close_out;
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   // Read data stands only in the cycle after the strobe
   always @(posedge ref_clk) begin
      if (rd_seen) begin
         e_r = exp_q.pop_front();
         `CHK(rdat, e_r)
      end
      rd_seen <= rd;
   end

   // Transmit clocks on channel 5 since the last mark start seen on its driven line
   always @(posedge ref_clk) begin
      ck5_d <= tx_line_clock[5];
      mk5_d <= txa[5] | txb[5];
      if (!oen[5] && (txa[5] | txb[5]) && !mk5_d) quiet <= 0;
      else if (tx_line_clock[5] && !ck5_d) quiet <= quiet + 1;
   end

   initial begin
      #500000;
      errors++;
      close_out();
   end

   initial begin
      k = $urandom(32'h78AB76E8);
      tick(16);
      reset_n <= 1'b1;
      tick(4);
      rd_reg(ADDR_GLOBAL, GLOBAL_RST);
      rd_reg(6'h3F, 8'h00);
      for (k = 0; k < NCH; k++) begin
         wv[k] = DW'($urandom);
         wr6[k] = wv[k][CB_RXHIZ];
         rd_reg(AW'(STAT_BASE + k), 8'h00);
         wr_reg(AW'(CTRL_BASE + k), wv[k]);
         rd_reg(AW'(CTRL_BASE + k), wv[k]);
      end
      tick(1);
      `CHK(hiz, wr6)
      for (k = 0; k < NCH; k++) wr_reg(AW'(CTRL_BASE + k), role[k]);
      run <= 1'b1;
      prev_a = '0;
      // One tick per pass; every channel checked against its own role
      for (k = 0; k < 12; k++) begin
         @(negedge tx_line_clock[0]);
         pa = tx_pos_rail;
         pn = tx_neg_rail;
         tick(5);
         lph = (k >= 4 && k < 8);
         m = (k < 4 || k > 8) ? 8'hFA : 8'hF8;
         ao = (k > 4 && k < 8) ? 8'h03 : 8'h01;
         alt = {6'h00, (k == 6 || k == 7), (k > 0)};
         `CHK(txa & m, pa & m)
         `CHK(txb & m, pn & m)
         `CHK((txa ^ txb) & ao, ao)
         `CHK(txa & alt, ~prev_a & alt)
         `CHK({txa[2], txb[2]}, {rxa[2], rxb[2]})
         `CHK(rxp & 8'hE7, rxa & 8'hE7)
         `CHK(rxn & 8'hE7, rxb & 8'hE7)
         `CHK({rxp[3], rxn[3], rxc[3]}, {pa[3], pn[3], 1'b0})
         `CHK({rxp[4], rxn[4]}, {pa[4], pn[4]})
         `CHK(losa[1], lph)
         prev_a = txa;
         @(posedge ref_clk);
         r1 = NCH'($urandom);
         r2 = NCH'($urandom);
         rxa <= r1;
         rxb <= ~r1 & r2;
         los <= (k == 3) ? 8'h02 : (k == 7) ? 8'h00 : los;
      end
      @(posedge ref_clk);
      los <= 8'hFF;
      tick(6);
      `CHK(losa, 8'hFF)
      // Primary channel 6 alarm pin starts the swap to backup channel 7
      `CHK({oen[7], hiz[7], losa[6]}, 3'b111)
      wr_reg(AW'(CTRL_BASE + 7), 8'h00);
      wr_reg(AW'(CTRL_BASE + 6), 8'hC0);
      tick(2);
      `CHK({hiz[7:6], oen[7:6]}, 4'b0101)
      rd_reg(AW'(STAT_BASE + 6), 8'h01);
      los <= 8'h00;
      // Transmitter off counts as no output
      wr_reg(AW'(CTRL_BASE + 5), 8'hA0);
      for (n = 0; dff[5] !== 1'b1 && n < 1500; n++) tick(1);
      `CHK({dff[5], quiet inside {[128:130]}}, 2'b11)
      tick(3);
      `CHK(int_n, 1'b0)
      rd_reg(AW'(STAT_BASE + 5), 8'h06);
      tick(2);
      `CHK(int_n, 1'b1)
      rd_reg(AW'(STAT_BASE + 5), 8'h02);
      wr_reg(AW'(CTRL_BASE + 5), 8'h20);
      for (n = 0; dff[5] !== 1'b0 && n < 1000; n++) tick(1);
      `CHK(dff[5], 1'b0)
      tick(3);
      `CHK(int_n, 1'b0)
      rd_reg(AW'(STAT_BASE + 5), 8'h04);
      for (k = 0; k < NCH; k++) wr_reg(AW'(CTRL_BASE + k), 8'h00);
      wr_reg(ADDR_GLOBAL, 8'h01);
      @(posedge ref_clk);
      run <= 1'b0;
      idle <= 1'b0;
      tick(24);
      `CHK(oen, 8'hFF)
      @(posedge ref_clk);
      idle <= 1'b1;
      tick(24);
      `CHK(oen, 8'h00)
      last = {txa[6], txb[6]};
      n = 0;
      repeat (96) begin
         tick(1);
         if ({txa[6], txb[6]} != last) n++;
         last = {txa[6], txb[6]};
      end
      `CHK(n inside {[3:5]}, 1'b1)
      close_out();
   end
endmodule
